// ===== core/rov_core.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module rov_core import rov_pkg::*; #(
    parameter int TICK_LEN = TICK_CYCLES, // Cycles per 10 ms timer tick
    parameter int MEAS_W = 16             // Measurement width
) (
    input wire logic pclk,                   // APB clock, 40 MHz
    input wire logic presetn,                // Async reset, active low
    input wire logic psel,                   // APB select
    input wire logic penable,                // APB enable
    input wire logic pwrite,                 // APB direction
    input wire logic [7:0] paddr,            // APB byte address
    input wire logic [31:0] pwdata,          // APB write data
    output logic [31:0] prdata,              // APB read data
    output logic pready,                     // APB ready
    output logic pslverr,                    // APB error
    input wire logic [MEAS_W-1:0] residual_voltage, // Sample, 0.1 % of rated
    input wire logic meas_valid,             // New sample strobe
    input wire logic ext_block_in_a,         // External block A
    input wire logic ext_block_in_b,         // External block B
    input wire logic ext_block_in_c,         // External block C
    input wire logic reset_button,           // Front reset button
    input wire logic step_button,            // Front step button
    input wire logic internal_fault,         // Permanent fault detected
    output stage_out_t low_out,              // Low-set stage outputs
    output stage_out_t high_out,             // High-set stage outputs
    output logic internal_fault_alarm,       // Self-supervision alarm
    output logic record_erase                // Pulse: erase recorded data
);
    localparam int TW = $clog2(TICK_LEN + 1); // Prescaler width

    logic [31:0] options_reg;            // Switch groups
    logic [15:0] start_set_reg [2];      // Threshold settings
    logic [15:0] delay_set_reg [2];      // Delay settings
    logic [TW-1:0] tick_cnt_reg;         // Tick prescaler
    logic tick;                          // One-cycle timer tick
    logic [MEAS_W-1:0] meas_reg;         // Held sample
    logic buttons_both_reg;              // Previous both-buttons state
    logic cmd_keep;                      // Reset keeping records
    logic cmd_erase;                     // Reset erasing records
    logic both_pressed;                  // Step and reset held together
    logic out_release;                   // Release latched outputs
    logic ind_clear;                     // Clear latched indicators
    logic [15:0] thr_eff [2];            // Clamped thresholds
    logic [15:0] dly_eff [2];            // Clamped delays
    logic [1:0] inhibit;                 // Trip inhibits
    logic [1:0] start_now;               // Live start
    logic [1:0] trip_now;                // Live trip, after inhibit
    logic [1:0] trip_latch_reg;          // Latched trip outputs
    logic [1:0] start_ind_reg;           // Latched yellow memory
    logic [1:0] trip_ind_reg;            // Latched red memory
    logic [15:0] timer_reg [2];          // Stage delay timers
    stage_out_t out_reg [2];             // Registered outputs
    logic [31:0] rdata_next;             // Read mux
    logic addr_ok;                       // Mapped address
    logic wr_acc;                        // Write access phase

    // Clamp a setting into a range
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clamp

    // Delay range from two switches
    function automatic logic [15:0] dly_range(input logic [15:0] v, input logic a, input logic b);
        logic [15:0] r;
        r = clamp(v, DLY_MIN_S, DLY_MAX_S);
        if (a && b) begin
            r = clamp(v, DLY_MIN_L, DLY_MAX_L);
        end else if (a || b) begin
            r = clamp(v, DLY_MIN_M, DLY_MAX_M);
        end
        return r;
    endfunction : dly_range

    // Zero-wait slave: data is prepared in setup so prdata is a flop
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    always_comb begin
        addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);
        pslverr = psel && penable && !addr_ok;
    end

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            options_reg <= RST_OPTIONS;
            start_set_reg[0] <= RST_LOW_START;
            start_set_reg[1] <= RST_HIGH_START;
            delay_set_reg[0] <= RST_DELAY;
            delay_set_reg[1] <= RST_DELAY;
        end else if (wr_acc) begin
            unique case (paddr)
                OFS_OPTIONS: options_reg <= {14'h0000, pwdata[17:0]};
                OFS_LOW_START: start_set_reg[0] <= pwdata[15:0];
                OFS_HIGH_START: start_set_reg[1] <= pwdata[15:0];
                OFS_LOW_DELAY: delay_set_reg[0] <= pwdata[15:0];
                OFS_HIGH_DELAY: delay_set_reg[1] <= pwdata[15:0];
                default: ; // Command, status and unmapped store nothing
            endcase
        end
    end

    // Serial reset commands are pulses on write
    assign cmd_keep = wr_acc && (paddr == OFS_COMMAND) && pwdata[CMD_RESET_KEEP];
    assign cmd_erase = wr_acc && (paddr == OFS_COMMAND) && pwdata[CMD_RESET_ERASE];

    // Read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (paddr)
            OFS_OPTIONS: rdata_next = options_reg;
            OFS_LOW_START: rdata_next = {16'h0000, start_set_reg[0]};
            OFS_HIGH_START: rdata_next = {16'h0000, start_set_reg[1]};
            OFS_LOW_DELAY: rdata_next = {16'h0000, delay_set_reg[0]};
            OFS_HIGH_DELAY: rdata_next = {16'h0000, delay_set_reg[1]};
            OFS_STATUS: rdata_next = {17'h0_0000, internal_fault_alarm, trip_latch_reg, high_out, low_out, 4'h0};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Capture read data in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_next;
        end
    end

    // Timer tick prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= '0;
        end else if (tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end
    assign tick = (tick_cnt_reg == TW'(TICK_LEN - 1));

    // Hold the latest sample; comparisons use it between strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_reg <= '0;
        end else if (meas_valid) begin
            meas_reg <= residual_voltage;
        end
    end

    // Reset sources
    assign both_pressed = step_button && reset_button;
    assign out_release = both_pressed || cmd_keep || cmd_erase;
    assign ind_clear = reset_button || cmd_keep || cmd_erase;

    // Record erase pulse on the press edge or the erasing command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buttons_both_reg <= 1'b0;
            record_erase <= 1'b0;
        end else begin
            buttons_both_reg <= both_pressed;
            record_erase <= (both_pressed && !buttons_both_reg) || cmd_erase;
        end
    end

    // Settings decoded from switches
    always_comb begin
        thr_eff[0] = options_reg[SW_LOW_THR] ? clamp(start_set_reg[0], LOW_THR_MIN1, LOW_THR_MAX1)
                                             : clamp(start_set_reg[0], LOW_THR_MIN0, LOW_THR_MAX0);
        thr_eff[1] = options_reg[SW_HIGH_THR] ? clamp(start_set_reg[1], HIGH_THR_MIN1, HIGH_THR_MAX1)
                                              : clamp(start_set_reg[1], HIGH_THR_MIN0, HIGH_THR_MAX0);
        dly_eff[0] = dly_range(delay_set_reg[0], options_reg[SW_LOW_RANGE_A], options_reg[SW_LOW_RANGE_B]);
        dly_eff[1] = dly_range(delay_set_reg[1], options_reg[SW_HIGH_RANGE_A], options_reg[SW_HIGH_RANGE_B]);
    end

    // Per-stage decision logic
    for (genvar s = 0; s < 2; s++) begin : g_stage
        logic [1:0] route; // Inhibit source select
        logic enabled;     // Stage in operation
        logic ymode;       // Yellow latching
        logic rmode;       // Red latching
        logic trip_live;   // Trip, latched or live
        logic red_on;      // Red shown
        assign route = options_reg[ROUTE_LSB + 2*s +: 2];
        assign ymode = options_reg[IND_MODE_LSB + 2*s];
        assign rmode = options_reg[IND_MODE_LSB + 2*s + 1];
        // High-set stage out of function on infinite setting
        assign enabled = (s == 0) || (start_set_reg[s] != THR_INFINITE);

        // Inhibit routed from one external input or none
        always_comb begin
            unique case (route)
                2'd0: inhibit[s] = 1'b0;
                2'd1: inhibit[s] = ext_block_in_a;
                2'd2: inhibit[s] = ext_block_in_b;
                2'd3: inhibit[s] = ext_block_in_c;
            endcase
        end

        // Start is a plain comparison so it drops with the voltage
        assign start_now[s] = enabled && (meas_reg > MEAS_W'(thr_eff[s]));
        // Inhibit gates trip only; timer keeps running
        assign trip_now[s] = start_now[s] && (timer_reg[s] >= dly_eff[s]) && !inhibit[s];

        // Definite delay timer, cleared as soon as start drops
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                timer_reg[s] <= 16'h0000;
            end else if (!start_now[s]) begin
                timer_reg[s] <= 16'h0000;
            end else if (tick && timer_reg[s] != 16'hFFFF) begin
                timer_reg[s] <= timer_reg[s] + 16'h0001;
            end
        end

        // Output latch; a new trip wins over a release in the same cycle
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                trip_latch_reg[s] <= 1'b0;
            end else if (trip_now[s] && options_reg[SW_OUT_LATCH]) begin
                trip_latch_reg[s] <= 1'b1;
            end else if (out_release || !options_reg[SW_OUT_LATCH]) begin
                trip_latch_reg[s] <= 1'b0;
            end
        end

        // Indicator memories; set wins over clear
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                start_ind_reg[s] <= 1'b0;
                trip_ind_reg[s] <= 1'b0;
            end else begin
                start_ind_reg[s] <= ymode && (start_now[s] || (start_ind_reg[s] && !ind_clear));
                trip_ind_reg[s] <= rmode && (trip_now[s] || (trip_ind_reg[s] && !ind_clear));
            end
        end

        assign trip_live = trip_now[s] || trip_latch_reg[s];
        assign red_on = trip_now[s] || trip_ind_reg[s];

        // Registered outputs, all blocked while the alarm stands
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_reg[s] <= '0;
            end else if (internal_fault) begin
                out_reg[s] <= '0;
            end else begin
                out_reg[s].start <= start_now[s];
                out_reg[s].trip <= trip_live;
                out_reg[s].red <= red_on;
                // Yellow gives way to red when the stage operates
                out_reg[s].yellow <= (start_now[s] || start_ind_reg[s]) && !red_on;
            end
        end
    end

    assign low_out = out_reg[0];
    assign high_out = out_reg[1];

    // Self-supervision alarm follows the fault detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_fault_alarm <= 1'b0;
        end else begin
            internal_fault_alarm <= internal_fault;
        end
    end
endmodule : rov_core

// ===== core/rov_pkg.sv
// Contract
// - Stage starts when voltage exceeds threshold
// - Start asserts flag and yellow indicator
// - Sustained overvoltage beyond delay asserts trip
// - Operating stage turns indicator yellow to red
// - Each indicator selectable self-reset or latching
// - Reset button or either command clears indicators
// - Low inhibit suppresses low-set trip only
// - High inhibit suppresses high-set trip only
// - Routing switches pick external input per inhibit
// - Switches 1,2 select low delay range
// - None short, one middle, both long
// - Switches 7,8 select high delay range
// - Switch 5 selects low threshold range
// - Switch 6 selects high threshold range
// - Infinite setting disables high-set stage entirely
// - Switch 4 latches operated trip outputs
// - Buttons together or either command release
// - First command keeps records, others erase
// - Internal fault raises alarm, blocks outputs
package rov_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_OPTIONS = 8'h00;
    localparam logic [7:0] OFS_LOW_START = 8'h04;
    localparam logic [7:0] OFS_HIGH_START = 8'h08;
    localparam logic [7:0] OFS_LOW_DELAY = 8'h0C;
    localparam logic [7:0] OFS_HIGH_DELAY = 8'h10;
    localparam logic [7:0] OFS_COMMAND = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // Option register field positions
    localparam int SW_LOW_RANGE_A = 0;
    localparam int SW_LOW_RANGE_B = 1;
    localparam int SW_OUT_LATCH = 3;
    localparam int SW_LOW_THR = 4;
    localparam int SW_HIGH_THR = 5;
    localparam int SW_HIGH_RANGE_A = 6;
    localparam int SW_HIGH_RANGE_B = 7;
    localparam int IND_MODE_LSB = 8;
    localparam int ROUTE_LSB = 12;
    // Command bits
    localparam int CMD_RESET_KEEP = 0;
    localparam int CMD_RESET_ERASE = 1;
    // Reset values
    localparam logic [31:0] RST_OPTIONS = 32'h0000_0000;
    localparam logic [15:0] RST_LOW_START = 16'h0064;
    localparam logic [15:0] RST_HIGH_START = 16'hFFFF;
    localparam logic [15:0] RST_DELAY = 16'h0064;
    // Threshold setting meaning infinite
    localparam logic [15:0] THR_INFINITE = 16'hFFFF;
    // Threshold limits, units of 0.1 % of rated voltage
    localparam logic [15:0] LOW_THR_MIN0 = 16'h0014;
    localparam logic [15:0] LOW_THR_MAX0 = 16'h00C8;
    localparam logic [15:0] LOW_THR_MIN1 = 16'h0064;
    localparam logic [15:0] LOW_THR_MAX1 = 16'h03E8;
    localparam logic [15:0] HIGH_THR_MIN0 = 16'h0064;
    localparam logic [15:0] HIGH_THR_MAX0 = 16'h0320;
    localparam logic [15:0] HIGH_THR_MIN1 = 16'h0014;
    localparam logic [15:0] HIGH_THR_MAX1 = 16'h00A0;
    // Delay limits, units of 10 ms
    localparam logic [15:0] DLY_MIN_S = 16'h0005;
    localparam logic [15:0] DLY_MAX_S = 16'h0064;
    localparam logic [15:0] DLY_MIN_M = 16'h0032;
    localparam logic [15:0] DLY_MAX_M = 16'h03E8;
    localparam logic [15:0] DLY_MIN_L = 16'h01F4;
    localparam logic [15:0] DLY_MAX_L = 16'h2710;
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // Per-stage outputs carried together
    typedef struct packed {
        logic start;   // Start flag
        logic trip;    // Trip flag
        logic yellow;  // Yellow indicator
        logic red;     // Red indicator
    } stage_out_t;
endpackage : rov_pkg

// ===== dv/rov_checker.sv
`timescale 1ns/1ps
module rov_checker import rov_pkg::*; (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic meas_valid, // Sample strobe
    input wire logic reset_button, // Reset key
    input wire logic step_button, // Step key
    input wire logic internal_fault, // Fault input
    input wire stage_out_t low_out, // Low stage outputs
    input wire stage_out_t high_out, // High stage outputs
    input wire logic internal_fault_alarm, // Alarm
    input wire logic record_erase // Erase pulse
);
    // Single domain, so clock and reset are stated once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_FAULT_ALARM: assert property (internal_fault |=> internal_fault_alarm)
        else $error("no alarm after fault");
    AST_FAULT_BLOCK: assert property (internal_fault_alarm |-> low_out == '0 && high_out == '0)
        else $error("outputs live while blocked");
    // A start may only follow a fresh sample by two cycles
    AST_LOW_START_SAMPLE: assert property ($rose(low_out.start) |-> $past(meas_valid, 2))
        else $error("low start without sample");
    AST_HIGH_START_SAMPLE: assert property ($rose(high_out.start) |-> $past(meas_valid, 2))
        else $error("high start without sample");
    AST_LOW_START_LIT: assert property (low_out.start |-> low_out.yellow || low_out.red)
        else $error("low start unlit");
    // Shortest delay is five ticks, so start must precede trip
    AST_LOW_TRIP_LATE: assert property ($rose(low_out.trip) |-> low_out.red && $past(low_out.start, 5))
        else $error("low trip early or not red");
    AST_HIGH_TRIP_LATE: assert property ($rose(high_out.trip) |-> high_out.red && $past(high_out.start, 5))
        else $error("high trip early or not red");
    AST_ERASE_PULSE: assert property (record_erase |=> !record_erase)
        else $error("erase longer than a cycle");
    AST_ERASE_KEYS: assert property ($rose(reset_button && step_button) && !internal_fault_alarm
        |-> ##[1:2] record_erase)
        else $error("keys did not erase");
endmodule : rov_checker

bind rov_core rov_checker u_chk (.pclk(pclk), .presetn(presetn), .meas_valid(meas_valid),
    .reset_button(reset_button), .step_button(step_button), .internal_fault(internal_fault),
    .low_out(low_out), .high_out(high_out), .internal_fault_alarm(internal_fault_alarm), .record_erase(record_erase));

// ===== dv/rov_meas_model.sv
`timescale 1ns/1ps
module rov_meas_model #(
    parameter int PERIOD = 8 // Cycles between samples
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic [15:0] level, // Voltage to report
    output logic [15:0] residual_voltage, // Sample bus
    output logic meas_valid // Sample strobe
);
    int cnt; // Position within period
    // Bus toggles between strobes so a stale value never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            meas_valid <= 1'h0;
            residual_voltage <= 16'h0000;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            meas_valid <= (cnt == PERIOD - 1);
            residual_voltage <= (cnt == PERIOD - 1) ? level : ~residual_voltage;
        end
    end
endmodule : rov_meas_model

// ===== dv/residual_overvoltage_two_stage_logic_tb.sv
`timescale 1ns/1ps
module residual_overvoltage_two_stage_logic_tb import rov_pkg::*;;
    localparam int TL = 4; // Short tick keeps delays brief
    typedef struct packed {logic [31:0] data; logic rd; logic err;} apb_exp_t;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, mv, alarm, erase;
    logic rst_key = 1'h0, step_key = 1'h0, fault = 1'h0;
    logic [2:0] blk = 3'h0; // External blocks a, b, c
    logic [15:0] rv, level = 16'h0000;
    stage_out_t lo, hi;
    apb_exp_t expq[$]; // Notes of expected answers
    apb_exp_t e;
    int err_total = 0, compares = 0;
    always #12.5 pclk = ~pclk;
    rov_meas_model #(.PERIOD(8)) u_src (.pclk(pclk), .presetn(presetn), .level(level),
        .residual_voltage(rv), .meas_valid(mv));
    rov_core #(.TICK_LEN(TL)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .residual_voltage(rv), .meas_valid(mv), .ext_block_in_a(blk[0]), .ext_block_in_b(blk[1]),
        .ext_block_in_c(blk[2]), .reset_button(rst_key), .step_button(step_key), .internal_fault(fault),
        .low_out(lo), .high_out(hi), .internal_fault_alarm(alarm), .record_erase(erase));
    task automatic report_and_stop();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic hang(input string what);
        err_total++;
        $display("MISMATCH %0t timeout %s", $time, what);
        report_and_stop();
    endtask : hang
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        expq.push_back('{d, !wr, err});
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            n++;
            if (n > 20) hang("pready");
            @(posedge pclk);
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // Delays are rewritten to 5; the range switches clamp the stored value when it is used, not at write time
    task automatic cfg(input logic [31:0] opt);
        apb(1'h1, OFS_OPTIONS, opt, 1'h0);
        apb(1'h1, OFS_LOW_DELAY, 32'h5, 1'h0);
        apb(1'h1, OFS_HIGH_DELAY, 32'h5, 1'h0);
    endtask : cfg
    function automatic logic pick(input int s);
        return s == 0 ? lo.start : s == 1 ? lo.trip : s == 2 ? hi.start : hi.trip;
    endfunction : pick
    task automatic wait_bit(input int s, input logic val, input int lim);
        int n;
        n = 0;
        while (pick(s) !== val) begin
            n++;
            if (n > lim) hang("output");
            @(posedge pclk);
        end
    endtask : wait_bit
    // Compares each completed transfer with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'h1) begin
            e = expq.pop_front();
            chk(pslverr, e.err, "pslverr");
            if (e.rd) chk(prdata, e.data, "prdata");
        end
    end
    initial begin
        int d, tl, th, n;
        logic saw;
        void'($urandom(32'hDBE53A07));
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, OFS_LOW_START, 32'h64, 1'h0);
        apb(1'h0, OFS_HIGH_START, 32'hFFFF, 1'h0);
        apb(1'h0, 8'h1C, 32'h0, 1'h1);
        cfg(32'h0);
        level <= 16'h0384;
        wait_bit(1, 1'h1, 60);
        chk(hi, 4'h0, "high off");
        level <= 16'h0000;
        wait_bit(0, 1'h0, 40);
        apb(1'h1, OFS_HIGH_START, 32'h64, 1'h0);
        // Every delay range code on both stages at once
        for (int c = 0; c < 4; c++) begin
            d = (c == 0) ? 5 : (c == 3) ? 500 : 50;
            cfg(c | (c << 6));
            level <= 16'(101 + $urandom % 800);
            wait_bit(0, 1'h1, 40);
            chk({lo, hi}, 8'hAA, "start");
            tl = -1;
            th = -1;
            n = 0;
            while ((tl < 0 || th < 0) && n < 2100) begin
                @(posedge pclk);
                n++;
                if (lo.trip === 1'h1 && tl < 0) tl = n;
                if (hi.trip === 1'h1 && th < 0) th = n;
            end
            chk(tl >= (d - 1) * TL && tl <= d * TL + 4, 1'h1, "low delay");
            chk(th >= (d - 1) * TL && th <= d * TL + 4, 1'h1, "high delay");
            chk({lo, hi}, 8'hDD, "trip");
            level <= 16'h0000;
            wait_bit(0, 1'h0, 40);
            repeat (2) @(posedge pclk);
            chk({lo, hi}, 8'h00, "drop");
        end
        // Upper low range raises the low floor, lower high range caps the high threshold
        apb(1'h1, OFS_LOW_START, 32'h10, 1'h0);
        apb(1'h1, OFS_HIGH_START, 32'h3E8, 1'h0);
        cfg(32'h30);
        level <= 16'h0050;
        repeat (20) @(posedge pclk);
        chk({lo, hi}, 8'h00, "low range floor");
        level <= 16'h00B4;
        wait_bit(0, 1'h1, 40);
        chk({lo, hi}, 8'hAA, "high range cap");
        level <= 16'h0000;
        wait_bit(0, 1'h0, 40);
        apb(1'h1, OFS_LOW_START, 32'h64, 1'h0);
        apb(1'h1, OFS_HIGH_START, 32'h64, 1'h0);
        // Low routed from a, high from b; c must not matter
        cfg(32'h9000);
        blk <= 3'h3;
        level <= 16'h0384;
        wait_bit(0, 1'h1, 40);
        repeat (40) @(posedge pclk);
        chk({lo, hi}, 8'hAA, "inhibit");
        blk <= 3'h6;
        repeat (4) @(posedge pclk);
        chk({lo, hi}, 8'hDA, "unblock");
        level <= 16'h0000;
        blk <= 3'h0;
        wait_bit(0, 1'h0, 40);
        // Latched trip released by command keep, command erase, both keys
        for (int m = 0; m < 3; m++) begin
            cfg(32'h8);
            level <= 16'h0384;
            wait_bit(1, 1'h1, 60);
            level <= 16'h0000;
            wait_bit(0, 1'h0, 40);
            repeat (3) @(posedge pclk);
            chk(lo.trip, 1'h1, "latched");
            if (m < 2) apb(1'h1, OFS_COMMAND, 32'h1 << m, 1'h0);
            else begin
                rst_key <= 1'h1;
                step_key <= 1'h1;
            end
            saw = 1'h0;
            repeat (4) begin
                @(posedge pclk);
                saw |= erase;
            end
            rst_key <= 1'h0;
            step_key <= 1'h0;
            chk(saw, m > 0, "erase");
            chk(lo.trip, 1'h0, "release");
        end
        cfg(32'h100);
        level <= 16'h0384;
        wait_bit(0, 1'h1, 40);
        level <= 16'h0000;
        wait_bit(0, 1'h0, 40);
        chk(lo, 4'h2, "yellow held");
        rst_key <= 1'h1;
        @(posedge pclk);
        rst_key <= 1'h0;
        repeat (3) @(posedge pclk);
        chk(lo, 4'h0, "yellow cleared");
        level <= 16'h0384;
        wait_bit(0, 1'h1, 40);
        fault <= 1'h1;
        repeat (2) @(posedge pclk);
        chk({alarm, lo, hi}, 9'h100, "blocked");
        apb(1'h0, OFS_STATUS, 32'h4000, 1'h0);
        // Let the monitor take the last answer before the run ends
        @(posedge pclk);
        report_and_stop();
    end
endmodule : residual_overvoltage_two_stage_logic_tb
